/* include/gpbsl_pkg.sv */
/*
 gpbsl_pkg: constants shared by the gpio bank with status indicator.
 assumes a 10 MHz core clock and a plain strobe-style register port.
*/
package gpbsl_pkg;
	// ==========================================================
	// geometry
	localparam int unsigned PAD_COUNT   = 10;             // number of pads
	localparam int unsigned AW          = 4;              // register address width
	// ==========================================================
	// register offsets (word index on the plain port)
	localparam logic [3:0]  REG_DIR     = 4'h0;           // 1 = output per pad
	localparam logic [3:0]  REG_OUT     = 4'h1;           // stored output values
	localparam logic [3:0]  REG_IN      = 4'h2;           // live pad levels
	localparam logic [3:0]  REG_PULL    = 4'h3;           // pull-down enables
	localparam logic [3:0]  REG_FUNC    = 4'h4;           // alternate function code, pad 0
	localparam logic [3:0]  REG_NET     = 4'h5;           // network state for indicator
	// ==========================================================
	// reset values
	localparam logic [9:0]  DIR_RST     = 10'h000;        // all inputs
	localparam logic [9:0]  OUT_RST     = 10'h000;
	localparam logic [9:0]  PULL_RST    = 10'h3FF;        // all pull-downs on
	localparam logic [1:0]  FUNC_RST    = 2'h0;
	localparam logic [2:0]  NET_RST     = 3'h0;           // device off
	// ==========================================================
	// function codes for pad 0
	localparam logic [1:0]  FUNC_IN     = 2'h0;
	localparam logic [1:0]  FUNC_OUT    = 2'h1;
	localparam logic [1:0]  FUNC_STATUS = 2'h2;
	// ==========================================================
	// network states
	typedef enum logic [2:0] {
		NET_OFF     = 3'h0,
		NET_NOREG   = 3'h1,
		NET_IDLE    = 3'h2,
		NET_PSAVE   = 3'h3,
		NET_CONNECT = 3'h4
	} gpbsl_net_t;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned ON_MS       = 1000;           // indicator on time
	localparam int unsigned OFF_MS      = 2000;           // indicator off time
	localparam int unsigned ON_CYC      = ON_MS * (CLK_HZ / 1000);
	localparam int unsigned PERIOD_CYC  = (ON_MS + OFF_MS) * (CLK_HZ / 1000);
endpackage

/* logic/gpbsl_sync.sv */
/*
 gpbsl_sync: two-flop synchroniser for the pad inputs.
 assumes inputs arrive asynchronously to clock.
*/
`timescale 1ns/1ps
module gpbsl_sync #(
	parameter int unsigned W = 10
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;   // first stage, read only by second
		logic [W-1:0] stab;   // second stage
	} gpbsl_sync_t;
	gpbsl_sync_t st_r;
	gpbsl_sync_t st_nxt;
	// ==========================================================
	// next state
	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = async_in;
		st_nxt.stab = st_r.meta;
	end
	// ==========================================================
	// register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign sync_out = st_r.stab;
endmodule

/* logic/gpbsl_blink.sv */
/*
 gpbsl_blink: status indicator pattern generator.
 assumes net_state is from logic on the same clock and wake_evt is a
 one-cycle pulse on that clock.
*/
`timescale 1ns/1ps
module gpbsl_blink #(
	parameter int unsigned PERIOD = gpbsl_pkg::PERIOD_CYC,
	parameter int unsigned ON_LEN = gpbsl_pkg::ON_CYC
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] net_state,
	input  wire logic       wake_evt,
	output logic            led_level
);
	typedef struct packed {
		logic [31:0] cnt;    // position within the blink period
		logic        led;    // indicator level
	} gpbsl_blink_t;
	gpbsl_blink_t st_r;
	gpbsl_blink_t st_nxt;
	logic         phase_on;
	// ==========================================================
	// pattern and state selection
	always_comb begin
		st_nxt   = st_r;
		phase_on = (st_r.cnt < 32'(ON_LEN));                          // [RULE13]
		// free-running 3 s counter
		if (st_r.cnt >= 32'(PERIOD - 1)) begin
			st_nxt.cnt = '0;                                           // [RULE13]
		end else begin
			st_nxt.cnt = st_r.cnt + 32'h0000_0001;
		end
		case (net_state)
			gpbsl_pkg::NET_OFF: begin
				st_nxt.led = 1'b0;                                     // [RULE9]
			end
			gpbsl_pkg::NET_NOREG: begin
				st_nxt.led = 1'b1;                                     // [RULE9]
			end
			gpbsl_pkg::NET_IDLE: begin
				st_nxt.led = phase_on;                                 // [RULE10]
			end
			gpbsl_pkg::NET_CONNECT: begin
				st_nxt.led = phase_on;                                 // [RULE11]
			end
			gpbsl_pkg::NET_PSAVE: begin
				// only toggles on paging-synchronised wake-ups
				if (wake_evt) begin
					st_nxt.led = ~st_r.led;                            // [RULE12]
				end
			end
			default: begin
				st_nxt.led = 1'b0;
			end
		endcase
	end
	// ==========================================================
	// register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign led_level = st_r.led;
endmodule

/* logic/gpbsl_top.sv */
/*
 gpbsl_top: ten-pad general purpose i/o bank with a status indicator on pad 0.
 assumes a single 10 MHz clock, synchronous reset, a plain register port
 and that the pad ring resolves the wire from pad_out/pad_oe/pad_pd.
*/
// Behaviour
// [RULE1] ten pads, each input or output
// [RULE2] reset: all inputs with pull-down on
// [RULE3] input read returns sampled pad level
// [RULE4] writes to input pads change nothing
// [RULE5] output drives stored value, readable back
// [RULE6] outputs drive both levels push-pull
// [RULE7] alternate function owns pad level
// [RULE8] pad 0 function code 2 selects indicator
// [RULE9] off low; not registered high
// [RULE10] idle: 1 s on, 2 s off
// [RULE11] connecting: 1 s on, 2 s off
// [RULE12] power saving: update on wake-ups only
// [RULE13] 3 s counter, high first second
`timescale 1ns/1ps
module gpbsl_top #(
	parameter int unsigned N          = gpbsl_pkg::PAD_COUNT,
	parameter int unsigned PERIOD_CYC = gpbsl_pkg::PERIOD_CYC,
	parameter int unsigned ON_CYC     = gpbsl_pkg::ON_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        wake_evt,
	input  wire logic [N-1:0] pad_in,
	output logic      [N-1:0] pad_out,
	output logic      [N-1:0] pad_oe,
	output logic      [N-1:0] pad_pd
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [N-1:0] dir;    // 1 = output
		logic [N-1:0] outv;   // stored output values
		logic [N-1:0] pull;   // pull-down enables
		logic [1:0]   func;   // pad 0 function code
		logic [2:0]   net;    // network state
		logic [31:0]  rdata;  // read data, valid one cycle after strobe
	} gpbsl_top_t;
	gpbsl_top_t   st_r;
	gpbsl_top_t   st_nxt;
	logic [N-1:0] pad_sync;   // synchronised pad levels
	logic         led_level;  // indicator pattern
	logic         alt_on;     // pad 0 in indicator mode
	// ==========================================================
	// pad input synchroniser
	gpbsl_sync #(
		.W (N)
	) u_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (pad_in),
		.sync_out (pad_sync)
	);
	// ==========================================================
	// indicator pattern
	gpbsl_blink #(
		.PERIOD (PERIOD_CYC),
		.ON_LEN (ON_CYC)
	) u_blink (
		.clock     (clock),
		.rst       (rst),
		.net_state (st_r.net),
		.wake_evt  (wake_evt),
		.led_level (led_level)
	);
	assign alt_on = (st_r.func == gpbsl_pkg::FUNC_STATUS);          // [RULE8]
	// ==========================================================
	// register writes and reads
	always_comb begin
		st_nxt       = st_r;
		st_nxt.rdata = '0;
		if (reg_wr) begin
			case (reg_addr)
				gpbsl_pkg::REG_DIR: begin
					st_nxt.dir = reg_wdata[N-1:0];                     // [RULE1]
				end
				gpbsl_pkg::REG_OUT: begin
					// only output-configured bits take the write
					st_nxt.outv = (reg_wdata[N-1:0] & st_r.dir)
					            | (st_r.outv & ~st_r.dir);           // [RULE4] [RULE5]
				end
				gpbsl_pkg::REG_PULL: begin
					st_nxt.pull = reg_wdata[N-1:0];
				end
				gpbsl_pkg::REG_FUNC: begin
					st_nxt.func = reg_wdata[1:0];                      // [RULE8]
					// codes 0 and 1 also set pad 0 direction
					if (reg_wdata[1:0] == gpbsl_pkg::FUNC_IN) begin
						st_nxt.dir[0] = 1'b0;
					end else if (reg_wdata[1:0] == gpbsl_pkg::FUNC_OUT) begin
						st_nxt.dir[0] = 1'b1;
					end
				end
				gpbsl_pkg::REG_NET: begin
					st_nxt.net = reg_wdata[2:0];
				end
				default: begin
					// unmapped write ignored
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				gpbsl_pkg::REG_DIR: begin
					st_nxt.rdata = 32'(st_r.dir);
				end
				gpbsl_pkg::REG_OUT: begin
					st_nxt.rdata = 32'(st_r.outv);                     // [RULE5]
				end
				gpbsl_pkg::REG_IN: begin
					st_nxt.rdata = 32'(pad_sync);                      // [RULE3]
				end
				gpbsl_pkg::REG_PULL: begin
					st_nxt.rdata = 32'(st_r.pull);
				end
				gpbsl_pkg::REG_FUNC: begin
					st_nxt.rdata = 32'(st_r.func);
				end
				gpbsl_pkg::REG_NET: begin
					st_nxt.rdata = 32'(st_r.net);
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;                      // unmapped reads zero
				end
			endcase
		end
	end
	// ==========================================================
	// register
	always_ff @(posedge clock) begin
		if (rst) begin
			st_r.dir   <= gpbsl_pkg::DIR_RST;                           // [RULE2]
			st_r.outv  <= gpbsl_pkg::OUT_RST;
			st_r.pull  <= gpbsl_pkg::PULL_RST;                          // [RULE2]
			st_r.func  <= gpbsl_pkg::FUNC_RST;
			st_r.net   <= gpbsl_pkg::NET_RST;
			st_r.rdata <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	// ==========================================================
	// pad drive: push-pull, both levels driven when enabled
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pad
			if (g == 0) begin : g_alt
				// indicator overrides user state
				assign pad_out[g] = alt_on ? led_level : st_r.outv[g];     // [RULE7] [RULE6]
				assign pad_oe[g]  = alt_on | st_r.dir[g];                  // [RULE7]
				assign pad_pd[g]  = ~pad_oe[g] & st_r.pull[g];
			end else begin : g_plain
				assign pad_out[g] = st_r.outv[g];                          // [RULE6]
				assign pad_oe[g]  = st_r.dir[g];                           // [RULE1]
				assign pad_pd[g]  = ~st_r.dir[g] & st_r.pull[g];           // [RULE2]
			end
		end
	endgenerate
	assign reg_rdata = st_r.rdata;
endmodule

/* dv/gpbsl_pad_model.sv */
/*
 gpbsl_pad_model: outside parts and pull network on the ten pads.
 assumes pad_oe high means the bank drives the wire push-pull.
*/
`timescale 1ns/1ps
module gpbsl_pad_model #(
	parameter int unsigned N = 10
) (
	input  wire logic         clock,
	input  wire logic [N-1:0] pad_out,
	input  wire logic [N-1:0] pad_oe,
	input  wire logic [N-1:0] pad_pd,
	input  wire logic [N-1:0] ext_val,
	input  wire logic [N-1:0] ext_en,
	output logic      [N-1:0] pad_lvl
);
	// undriven and unpulled wires wander, never a held value
	logic [N-1:0] float_r = '0;
	always @(posedge clock) float_r <= ~float_r;
	// ==========================================================
	// wire level: bank driver wins, then the outside part, then the pull
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (pad_oe[i]) pad_lvl[i] = pad_out[i];
			else if (ext_en[i]) pad_lvl[i] = ext_val[i];
			else if (pad_pd[i]) pad_lvl[i] = 1'b0;
			else pad_lvl[i] = float_r[i];
		end
	end
endmodule

/* dv/gpbsl_top_asserts.sv */
/*
 gpbsl_top_asserts: port checks of the gpio bank.
 assumes the bench runs PERIOD_CYC=12 and ON_CYC=4.
*/
`timescale 1ns/1ps
module gpbsl_top_asserts #(
	parameter int unsigned N          = 10,
	parameter int unsigned PERIOD_CYC = 12,
	parameter int unsigned ON_CYC     = 4
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [3:0]   reg_addr,
	input  wire logic [31:0]  reg_wdata,
	input  wire logic         reg_wr,
	input  wire logic         reg_rd,
	input  wire logic [31:0]  reg_rdata,
	input  wire logic         wake_evt,
	input  wire logic [N-1:0] pad_in,
	input  wire logic [N-1:0] pad_out,
	input  wire logic [N-1:0] pad_oe,
	input  wire logic [N-1:0] pad_pd
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ==========================================================
	// shadow of function code and network state, seen from writes
	logic [1:0] func_r;
	logic [2:0] net_r;
	always_ff @(posedge clock) begin
		if (rst) begin
			func_r <= 2'h0;
			net_r  <= 3'h0;
		end else if (reg_wr && reg_addr == gpbsl_pkg::REG_FUNC) begin
			func_r <= reg_wdata[1:0];
		end else if (reg_wr && reg_addr == gpbsl_pkg::REG_NET) begin
			net_r <= reg_wdata[2:0];
		end
	end
	// ==========================================================
	// indicator mode settled: covers the one-cycle lag of the pattern
	sequence s_mode(logic [2:0] st);
		func_r == 2'h2 && $past(func_r) == 2'h2 && net_r == st && $past(net_r) == st;
	endsequence
	// ==========================================================
	// pad 0 history and age of a blinking mode: the blink is judged looking
	// back, so a later switch to another mode cannot break a check in flight
	logic [12:0] led_hist_r;   // pad 0 over the last 13 samples, bit 0 newest
	logic [4:0]  blink_age_r;  // samples spent in a blinking mode, saturates
	always_ff @(posedge clock) begin
		if (rst) begin
			led_hist_r  <= 13'h0000;
			blink_age_r <= 5'h00;
		end else begin
			led_hist_r <= {led_hist_r[11:0], pad_out[0]};
			if (func_r != 2'h2 || (net_r != 3'h2 && net_r != 3'h4)) begin
				blink_age_r <= 5'h00;
			end else if (blink_age_r != 5'h1F) begin
				blink_age_r <= blink_age_r + 5'h01;
			end
		end
	end
	// a rise well inside a blinking mode, so the whole history is pattern
	sequence s_blink_rise;
		func_r == 2'h2 && blink_age_r >= 5'h10 && $rose(pad_out[0]);
	endsequence
	// before the rise: 8 low, 4 high, then low again
	sequence s_blink_shape;
		led_hist_r == 13'h0F00;
	endsequence
	// ==========================================================
	a_reset_state: assert property (disable iff (1'b0) rst |=>
		pad_oe == '0 && pad_pd == '1) else $error("pads not inputs with pull after reset");
	a_rdata_live: assert property (reg_rd && reg_addr == gpbsl_pkg::REG_IN |=>
		reg_rdata == 32'($past(pad_in, 3))) else $error("input read wrong");
	a_drive_excl: assert property ((pad_oe & pad_pd) == '0)
		else $error("pull on a driven pad");
	a_dir_update: assert property (reg_wr && reg_addr == gpbsl_pkg::REG_DIR |=>
		pad_oe[N-1:1] == $past(reg_wdata[N-1:1])) else $error("direction not taken");
	a_out_drive: assert property (reg_wr && reg_addr == gpbsl_pkg::REG_OUT |=>
		((pad_out[N-1:1] ^ $past(reg_wdata[N-1:1])) & pad_oe[N-1:1]) == '0)
		else $error("output pad not driving written value");
	a_input_hold: assert property (reg_wr && reg_addr == gpbsl_pkg::REG_OUT |=>
		((pad_out[N-1:1] ^ $past(pad_out[N-1:1])) & ~pad_oe[N-1:1]) == '0)
		else $error("write changed an input pad");
	a_led_off: assert property (s_mode(3'h0) |-> pad_oe[0] && !pad_out[0])
		else $error("indicator not low when off");
	a_led_on: assert property (s_mode(3'h1) |-> pad_oe[0] && pad_out[0])
		else $error("indicator not high when unregistered");
	a_blink_shape: assert property (s_blink_rise |-> s_blink_shape)
		else $error("blink not 4 on 8 off");
	a_psave_hold: assert property (s_mode(3'h3) ##0 !$past(wake_evt) |->
		$stable(pad_out[0])) else $error("indicator moved without wake-up");
	a_psave_wake: assert property (s_mode(3'h3) ##0 $past(wake_evt) |->
		$changed(pad_out[0])) else $error("indicator ignored wake-up");
endmodule
bind gpbsl_top gpbsl_top_asserts #(.N(N), .PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC)) u_asserts (
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .wake_evt(wake_evt), .pad_in(pad_in),
	.pad_out(pad_out), .pad_oe(pad_oe), .pad_pd(pad_pd));

/* dv/gpio_bank_with_status_led_bench.sv */
/*
 gpio_bank_with_status_led_bench: self-checking bench of the gpio bank.
 assumes shortened blink counts: 12-cycle period, 4 cycles on.
*/
`timescale 1ns/1ps
module gpio_bank_with_status_led_bench;
	logic        clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, wake_evt = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [9:0]  pad_in, pad_out, pad_oe, pad_pd, ext_val = 10'h2C9, ext_en = 10'h3FF;
	int          n_errors = 0, compares = 0, hi;
	logic        v;
	always #50 clock = ~clock;
	gpbsl_top #(.N(10), .PERIOD_CYC(12), .ON_CYC(4)) u_gpbsl_top (.clock(clock), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .wake_evt(wake_evt), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .pad_pd(pad_pd));
	gpbsl_pad_model u_gpbsl_pad_model (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pd(pad_pd), .ext_val(ext_val), .ext_en(ext_en), .pad_lvl(pad_in));
	// ==========================================================
	// shared helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task tally_and_finish;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	task t_reset;
		#1 chk(pad_oe, 32'h0);
		chk(pad_pd, 32'h3FF);
		rd(gpbsl_pkg::REG_DIR, 32'h0);
		rd(gpbsl_pkg::REG_PULL, 32'h3FF);
		rd(gpbsl_pkg::REG_IN, 32'h2C9);
		@(posedge clock);
		ext_val <= 10'h136;
		repeat (2) @(posedge clock); // synchroniser needs two edges
		rd(gpbsl_pkg::REG_IN, 32'h136);
		$display("test reset done");
	endtask
	task t_io;
		wr(gpbsl_pkg::REG_OUT, 32'h3FF);
		rd(gpbsl_pkg::REG_OUT, 32'h0);
		wr(gpbsl_pkg::REG_DIR, 32'h3F0);
		wr(gpbsl_pkg::REG_OUT, 32'h0A5);
		rd(gpbsl_pkg::REG_OUT, 32'h0A0);
		chk(pad_oe, 32'h3F0);
		chk(pad_out & pad_oe, 32'h0A0);
		chk(pad_pd & pad_oe, 32'h0);
		// pad 1 let go by its outside part: only the pull-down holds it
		@(posedge clock);
		ext_en <= 10'h3FD;
		repeat (3) @(posedge clock);
		rd(gpbsl_pkg::REG_IN, 32'h0A4);
		rd(4'hF, 32'h0);
		$display("test io done");
	endtask
	task t_led;
		wr(gpbsl_pkg::REG_FUNC, 32'h2);
		wr(gpbsl_pkg::REG_NET, 32'h0);
		repeat (3) @(posedge clock);
		#1 chk({pad_oe[0], pad_out[0]}, 32'h2);
		wr(gpbsl_pkg::REG_NET, 32'h1);
		repeat (3) @(posedge clock);
		#1 chk({pad_oe[0], pad_out[0]}, 32'h3);
		// idle then connecting: four high cycles in any twelve
		for (int m = 2; m <= 4; m += 2) begin
			wr(gpbsl_pkg::REG_NET, 32'(m));
			repeat (30) @(posedge clock);
			hi = 0;
			repeat (12) begin
				@(posedge clock);
				#1 hi += int'(pad_out[0]);
			end
			chk(32'(hi), 32'h4);
		end
		wr(gpbsl_pkg::REG_NET, 32'h3);
		repeat (3) @(posedge clock);
		#1 v = pad_out[0];
		repeat (12) @(posedge clock);
		#1 chk(pad_out[0], v);
		@(posedge clock);
		wake_evt <= 1'b1;
		@(posedge clock);
		wake_evt <= 1'b0;
		// inverse kept to one bit: a widened invert would set the upper bits
		#1 chk(pad_out[0], {31'h0000_0000, ~v});
		$display("test indicator done");
	endtask
	// ==========================================================
	// watchdog: the tests need under two hundred cycles
	initial begin
		repeat (3000) @(posedge clock);
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_reset;
		t_io;
		t_led;
		tally_and_finish;
	end
endmodule
